// ### hw/host_io_port_interface.sv
`timescale 1ns/10ps
`include "host_port_consts.svh"
// Overview of operation
// R01 - Three byte ports decoded from selectable base
// R02 - Control bits act once, self clear
// R03 - Full reset reruns diagnostics, resets bus
// R04 - Self test busy, then setup and idle
// R05 - Logic reset abandons commands, sets setup, idle
// R06 - Interrupt clear empties flags, drops line
// R07 - Mailbox interrupts wait behind high ones
// R08 - High interrupts need no flags, port empty
// R09 - Bus reset request drives line 25 us
// R10 - Host writes zero to reserved control bits
// R11 - Diagnostics end sets setup or failed
// R12 - Failed stays until full reset
// R13 - Host runs mailbox init when needed
// R14 - Idle only when nothing outstanding
// R15 - Command write sets out full until taken
// R16 - Reply load sets in full, read clears
// R17 - Bad byte sets bad command, ends early
// R18 - Every command ends with command done
// R19 - Bad command valid only with done
// R20 - Status bit one reads zero
// R21 - Host never writes interrupt port
// R22 - Any flag sets bit seven and line
// R23 - Only external bus resets flag seen
// R24 - Resets also clear interrupt flags
// R25 - Only data reads have side effects
module host_io_port_interface
  import host_port_pkg::*;
#(
  parameter int FIFO_DEPTH = `HP_FIFO_DEPTH
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic [9:0] io_addr_i,
  input  wire logic [9:0] base_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  output logic            irq_o,
  output logic            scsi_rst_o,
  input  wire logic       scsi_rst_seen_i,
  output logic      [7:0] cmd_byte_o,
  output logic            cmd_valid_o,
  input  wire logic       cmd_taken_i,
  input  wire logic       cmd_bad_i,
  input  wire logic       cmd_done_i,
  input  wire logic       busy_i,
  input  wire logic       mbx_init_done_i,
  input  wire logic       outbox_free_i,
  input  wire logic       inbox_full_i,
  input  wire logic       diag_done_i,
  input  wire logic       diag_pass_i,
  output logic            proc_reset_o,
  output logic            abandon_o,
  input  wire logic       reply_valid_i,
  output logic            reply_ready_o,
  input  wire logic [7:0] reply_data_i
);
  localparam int RST_CYC = `HP_BUSRST_CYC;

  seq_e        state;
  status_s     status;
  logic [3:0]  flags;
  logic [3:0]  pend;
  logic [7:0]  reply_byte;
  logic [9:0]  rst_cnt;
  logic        rst_in_q;
  logic        rst_tail;
  logic        fifo_valid;
  logic [7:0]  fifo_data;

  // Address decode: the base selects a four-byte block, the low bits the port.
  wire       hit      = io_addr_i[9:2] == base_addr_i[9:2]; // R01
  wire [1:0] ofs      = io_addr_i[1:0];
  wire       wr_ctrl  = io_wr_i & hit & (ofs == `HP_OFS_CTRL);
  wire       wr_data  = io_wr_i & hit & (ofs == `HP_OFS_DATA);
  wire       rd_data  = io_rd_i & hit & (ofs == `HP_OFS_DATA); // R25
  wire       rd_hit   = io_rd_i & hit;
  // Writes to the interrupt port and bits 3..0 of control are ignored. R21 R10
  wire       do_full  = wr_ctrl & io_wdata_i[`HP_CB_FULL]; // R03
  wire       do_logic = wr_ctrl & io_wdata_i[`HP_CB_LOGIC] & ~do_full; // R05
  wire       do_clr   = wr_ctrl & io_wdata_i[`HP_CB_IRQCLR]; // R06
  wire       do_bus   = wr_ctrl & io_wdata_i[`HP_CB_BUSRST]; // R09
  wire       wipe     = do_full | do_logic; // R24

  // The reply byte moves from the buffer whenever the port is empty and the self test is over.
  wire       load     = fifo_valid & ~status.in_port_full & (state == ST_RUN);
  wire       test_end = (state == ST_TEST) & diag_done_i;

  // A bus reset echoed from our own drive must not flag; the tail covers one extra cycle.
  wire       ext_rst  = scsi_rst_seen_i & ~rst_in_q & ~scsi_rst_o & ~rst_tail; // R23

  // Raw events, merged with those still waiting to be posted.
  wire [3:0] ev       = {ext_rst, cmd_done_i, outbox_free_i, inbox_full_i};
  wire [3:0] want     = pend | ev;
  wire       hi_block = flags[3] | flags[2];
  // A reply byte loading this cycle counts as a full port, so completion never overtakes its data.
  wire       hi_ok    = (flags == 4'h0) & ~status.in_port_full & ~load;
  wire [3:0] post     = {want[3] & hi_ok, want[2] & hi_ok & ~want[3],
                         want[1:0] & {2{~hi_block}}}; // R07 R08
  wire [3:0] kept     = do_clr ? 4'h0 : flags; // R06
  wire [3:0] next_flags = wipe ? 4'h0 : (kept | post);
  wire [3:0] next_pend  = wipe ? 4'h0 : (want & ~post);

  // Interrupt flag port image; bits 6..4 are hard zero.
  wire [7:0] irq_view = {|flags, 3'h0, flags}; // R22
  wire [7:0] rd_mux   = (ofs == `HP_OFS_CTRL) ? status :
                        (ofs == `HP_OFS_DATA) ? reply_byte :
                        (ofs == `HP_OFS_IRQ)  ? irq_view : 8'h00;

  // Reply bytes queue here so the processor can run ahead of a slow host.
  reply_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_reply (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (reply_valid_i),
    .in_ready_o  (reply_ready_o),
    .in_data_i   (reply_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (load),
    .out_data_o  (fifo_data)
  );

  // Reset sequencer: power-on and full reset both run the self test.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      state <= ST_TEST;
    else if (do_full)
      state <= ST_TEST; // R03
    else
    begin
      case (state)
        ST_TEST: state <= diag_done_i ? ST_RUN : ST_TEST; // R11
        ST_RUN:  state <= ST_RUN;
        default: state <= ST_TEST;
      endcase
    end
  end

  // Status bits.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      status <= '{selftest_running: 1'b1, default: 1'b0};
    else
    begin
      status.zero_bit <= 1'b0; // R20
      status.selftest_running <= do_full | (status.selftest_running & ~test_end); // R04 R11
      if (do_full)
        status.selftest_failed <= 1'b0; // R12
      else if (test_end & ~diag_pass_i)
        status.selftest_failed <= 1'b1; // R11
      if (do_full)
        status.mailbox_setup_needed <= 1'b0;
      else if ((test_end & diag_pass_i) | do_logic)
        status.mailbox_setup_needed <= 1'b1; // R04 R05
      else if (mbx_init_done_i)
        status.mailbox_setup_needed <= 1'b0; // R13
      // Idle follows the processor only once the test is over. R14
      status.idle <= ~do_full & (test_end | do_logic |
                     (~busy_i & ~status.selftest_running));
      // A host write sets the flag; taking the byte clears it; the set wins. R15
      status.out_port_full <= wr_data | (status.out_port_full & ~cmd_taken_i & ~wipe);
      // Loading sets, the host read clears; load wins over a same-cycle read. R16
      status.in_port_full <= load | (status.in_port_full & ~rd_data & ~wipe);
      // Bad command rises on an invalid byte and is dropped when a new command is written with the done flag clear. R17 R19
      status.bad_command <= cmd_bad_i | (status.bad_command & ~wipe &
                            ~(wr_data & ~flags[2]));
    end
  end

  // Interrupt flags, waiting events and the line itself.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      flags <= 4'(`HP_IRQ_RST);
      pend  <= 4'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      flags <= next_flags; // R18
      pend  <= next_pend;
      irq_o <= |next_flags; // R22
    end
  end

  // Command byte out to the processor and reply byte in from the buffer.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      cmd_byte_o  <= `HP_DATA_RST;
      cmd_valid_o <= 1'b0;
      reply_byte  <= `HP_DATA_RST;
    end
    else
    begin
      cmd_byte_o  <= wr_data ? io_wdata_i : cmd_byte_o;
      cmd_valid_o <= wr_data | (cmd_valid_o & ~cmd_taken_i & ~wipe);
      reply_byte  <= load ? fifo_data : reply_byte;
    end
  end

  // Read data is registered and answers one cycle after the strobe.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      io_rdata_o <= 8'h00;
    else
      io_rdata_o <= rd_hit ? rd_mux : 8'h00;
  end

  // One-cycle command pulses toward the processor. R02
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      proc_reset_o <= 1'b0;
      abandon_o    <= 1'b0;
    end
    else
    begin
      proc_reset_o <= do_full; // R03
      abandon_o    <= do_logic; // R05
    end
  end

  // Bus reset drive; a new request restarts the full period.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      rst_cnt    <= 10'h000;
      scsi_rst_o <= 1'b0;
      rst_in_q   <= 1'b0;
      rst_tail   <= 1'b0;
    end
    else
    begin
      if (do_full | do_bus)
        rst_cnt <= 10'(RST_CYC - 1); // R09
      else if (rst_cnt != 10'h000)
        rst_cnt <= rst_cnt - 10'h001;
      scsi_rst_o <= do_full | do_bus | (rst_cnt != 10'h000);
      rst_in_q   <= scsi_rst_seen_i;
      rst_tail   <= scsi_rst_o;
    end
  end

  // Checks.
  logic [10:0] hi_cnt;
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      hi_cnt <= 11'h000;
    else if (do_full | do_bus)
      hi_cnt <= 11'h000;
    else if (scsi_rst_o)
      hi_cnt <= hi_cnt + 11'h001;
  end

  sequence s_full_write;
    do_full;
  endsequence
  sequence s_test_started;
    status.selftest_running & proc_reset_o & ~status.mailbox_setup_needed;
  endsequence
  sequence s_pass_end;
    test_end & diag_pass_i & ~do_full;
  endsequence

  a_full_reset_test: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R03
    s_full_write |=> s_test_started ##1 !proc_reset_o)
    else $error("full reset did not start the self test");
  a_ctrl_self_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R02
    (do_full | do_logic) ##1 ~do_full & ~do_logic |-> ##1 !proc_reset_o & !abandon_o)
    else $error("control pulse did not self clear");
  a_diag_pass_end: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R04
    s_pass_end |=> !status.selftest_running & status.mailbox_setup_needed & !status.selftest_failed)
    else $error("self test pass did not set setup needed");
  a_fail_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
    status.selftest_failed & ~do_full |=> status.selftest_failed)
    else $error("self test failure cleared without full reset");
  a_logic_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R05
    do_logic |=> abandon_o & status.mailbox_setup_needed & !irq_o & !status.selftest_running)
    else $error("logic reset effects missing");
  a_irq_clear_drop: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R06
    do_clr & (want == 4'h0) |=> !irq_o && flags == 4'h0)
    else $error("interrupt clear left flags set");
  a_low_held_back: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R07
    hi_block & ~do_clr & ~wipe |=> flags[1:0] == $past(flags[1:0]))
    else $error("mailbox interrupt posted over a high interrupt");
  a_high_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R08
    $rose(flags[2]) | $rose(flags[3]) |-> $past(flags) == 4'h0 && !$past(status.in_port_full) && !$past(load))
    else $error("high interrupt posted while blocked");
  a_bus_rst_len: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R09
    $fell(scsi_rst_o) |-> $past(hi_cnt) == 11'(RST_CYC - 1))
    else $error("bus reset drive length wrong");
  a_any_line: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R22
    irq_o == (flags != 4'h0))
    else $error("interrupt line disagrees with flags");
  a_out_full_set: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R15
    wr_data |=> status.out_port_full & cmd_valid_o ##0 cmd_byte_o == $past(io_wdata_i))
    else $error("command write did not set out full");
  a_in_full_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
    rd_data & ~load |=> !status.in_port_full)
    else $error("data read did not clear in full");
  a_status_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R20
    rd_hit & (ofs == `HP_OFS_CTRL) |=> io_rdata_o[1] == 1'b0)
    else $error("status bit one not zero");

  // Status bits follow their set and clear events one cycle later; a command end is posted or queued.
  a_in_full_set: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
    load |=> status.in_port_full)
    else $error("reply load did not set in full");
  a_out_full_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R15
    cmd_taken_i & ~wr_data |=> !status.out_port_full)
    else $error("taken byte left out full set");
  a_bad_cmd_set: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R17
    cmd_bad_i |=> status.bad_command)
    else $error("invalid byte did not set bad command");
  a_done_queued: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R18
    cmd_done_i & ~wipe |=> flags[2] | pend[2])
    else $error("command end was neither posted nor queued");
  a_idle_busy: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R14
    busy_i & ~test_end & ~do_logic |=> !status.idle)
    else $error("idle reported while commands outstanding");
  a_setup_cleared: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
    mbx_init_done_i & ~do_full & ~do_logic & ~test_end |=> !status.mailbox_setup_needed)
    else $error("mailbox setup flag not cleared by init");
  // A failed self test must leave the failure visible and the busy bit clear.
  a_diag_fail_end: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R11
    test_end & ~diag_pass_i & ~do_full |=> status.selftest_failed & !status.selftest_running)
    else $error("self test failure not reported");
  a_wipe_flags: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R24
    wipe |=> flags == 4'h0 && pend == 4'h0 && !irq_o)
    else $error("reset left interrupt state behind");
endmodule : host_io_port_interface

// ### hw/host_port_consts.svh
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
// Port offsets within the four-byte block.
`define HP_OFS_CTRL 2'h0
`define HP_OFS_DATA 2'h1
`define HP_OFS_IRQ 2'h2
// Control port bit positions.
`define HP_CB_FULL 7
`define HP_CB_LOGIC 6
`define HP_CB_IRQCLR 5
`define HP_CB_BUSRST 4
// Interrupt flag port bit positions.
`define HP_IB_ANY 7
`define HP_IB_SEEN 3
`define HP_IB_DONE 2
`define HP_IB_OBF 1
`define HP_IB_IBF 0
// Reset values.
`define HP_IRQ_RST 8'h00
`define HP_DATA_RST 8'h00
// Bus reset drive time and clock period.
`define HP_BUSRST_NS 25000
`define HP_CLK_NS 40
`define HP_BUSRST_CYC ((`HP_BUSRST_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
// Reply buffer shape.
`define HP_FIFO_DEPTH 16
`endif

// ### hw/host_port_pkg.sv
package host_port_pkg;
  // Status port layout, bit 7 down to bit 0.
  typedef struct packed {
    logic selftest_running;
    logic selftest_failed;
    logic mailbox_setup_needed;
    logic idle;
    logic out_port_full;
    logic in_port_full;
    logic zero_bit;
    logic bad_command;
  } status_s;
  // Reset sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_TEST = 2'b01,
    ST_RUN  = 2'b10
  } seq_e;
endpackage : host_port_pkg

// ### hw/reply_fifo.sv
`timescale 1ns/10ps
module reply_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  wire [AW:0]       next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data_o = mem[rd_ptr];
  // Ready and valid are registered from the next count, so full and empty never lie.
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      wr_ptr      <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr      <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count       <= next_count;
      in_ready_o  <= next_count != DEPTH[AW:0];
      out_valid_o <= next_count != '0;
    end
  end
  // Storage has no reset; only the pointers matter.
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : reply_fifo

// ### verification/adapter_proc_model.sv
`timescale 1ns/10ps
module adapter_proc_model (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_byte_i,
  input  wire logic       proc_reset_i,
  input  wire logic       pass_cfg_i,
  input  wire logic       reply_ready_i,
  output logic            cmd_taken_o,
  output logic            cmd_bad_o,
  output logic            cmd_done_o,
  output logic            diag_done_o,
  output logic            diag_pass_o,
  output logic            reply_valid_o,
  output logic      [7:0] reply_data_o
);
  int   dly;
  int   left;
  int   diag;
  logic acc;
  // Remember whether the push offered at this edge was accepted.
  always @(posedge ref_clk_i) acc <= reply_valid_o & reply_ready_i;
  // Slow processor: takes a byte six cycles late, answers and ends the command.
  always @(negedge ref_clk_i)
  begin
    {cmd_taken_o, cmd_bad_o, cmd_done_o, diag_done_o} = 4'h0;
    if (reset_i || proc_reset_i)
    begin
      diag = 20;
      left = 0;
      dly = 0;
      reply_valid_o = 1'b0;
    end
    else if (diag > 0)
    begin
      diag--;
      diag_done_o = (diag == 0);
      diag_pass_o = pass_cfg_i;
    end
    if (acc && left > 0)
    begin
      left--;
      reply_data_o++;
      reply_valid_o = (left > 0);
      cmd_done_o = (left == 0);
    end
    else if (cmd_valid_i && left == 0 && diag == 0)
    begin
      dly++;
      if (dly == 6)
      begin
        dly = 0;
        cmd_taken_o = 1'b1;
        cmd_bad_o = (cmd_byte_i == 8'hff);
        cmd_done_o = cmd_bad_o;
        left = cmd_bad_o ? 0 : (cmd_byte_i == 8'h20) ? 20 : 1;
        reply_data_o = (cmd_byte_i == 8'h20) ? 8'h00 : ~cmd_byte_i;
        reply_valid_o = !cmd_bad_o;
      end
    end
  end
  initial {cmd_taken_o, cmd_bad_o, cmd_done_o, diag_done_o, diag_pass_o, reply_valid_o, reply_data_o} = '0;
endmodule : adapter_proc_model

// ### verification/host_io_port_interface_tb_top.sv
`timescale 1ns/10ps
`include "host_port_consts.svh"
module host_io_port_interface_tb_top;
  import host_port_pkg::*;
  localparam logic [9:0] BASE = 10'h330;
  logic       clk, rst, rd_s, wr_s, busy, mbx, obf, ibf, ext, pass, tkn, bad, dn, dd, dp, rv, rr;
  logic       irq, logic_reset_abandon, cv, prst, abd;
  logic [9:0] addr;
  logic [7:0] wd, rdat, q, cb, rdd;
  int         mismatches, checked, n;
  // Clock of 25 MHz.
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  host_io_port_interface DUT (.ref_clk_i(clk), .reset_i(rst), .io_addr_i(addr), .base_addr_i(BASE),
    .io_rd_i(rd_s), .io_wr_i(wr_s), .io_wdata_i(wd), .io_rdata_o(q), .irq_o(irq), .scsi_rst_o(logic_reset_abandon),
    .scsi_rst_seen_i(logic_reset_abandon | ext), .cmd_byte_o(cb), .cmd_valid_o(cv), .cmd_taken_i(tkn), .cmd_bad_i(bad),
    .cmd_done_i(dn), .busy_i(busy), .mbx_init_done_i(mbx), .outbox_free_i(obf), .inbox_full_i(ibf),
    .diag_done_i(dd), .diag_pass_i(dp), .proc_reset_o(prst), .abandon_o(abd), .reply_valid_i(rv),
    .reply_ready_o(rr), .reply_data_i(rdd));
  adapter_proc_model PM (.ref_clk_i(clk), .reset_i(rst), .cmd_valid_i(cv), .cmd_byte_i(cb),
    .proc_reset_i(prst), .pass_cfg_i(pass), .reply_ready_i(rr), .cmd_taken_o(tkn), .cmd_bad_o(bad),
    .cmd_done_o(dn), .diag_done_o(dd), .diag_pass_o(dp), .reply_valid_o(rv), .reply_data_o(rdd));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // One strobe cycle; read data is taken in the cycle after the accepting edge.
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr_s = w;
    rd_s = !w;
    @(negedge clk);
    wr_s = 0;
    rd_s = 0;
    rdat = q;
  endtask : acc
  task automatic wr(input logic [1:0] o, input logic [7:0] d);
    acc(1, BASE + 10'(o), d);
  endtask : wr
  task automatic rd(input logic [1:0] o);
    acc(0, BASE + 10'(o), 8'h00);
  endtask : rd
  // Polls a status bit under a bound; running out ends the run.
  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i < 300; i++)
    begin
      rd(2'h0);
      if (rdat[b] === v)
        return;
    end
    mismatches++;
    close_out();
  endtask : wait_st
  task automatic pulse(input int k);
    @(negedge clk);
    {ext, mbx, obf, ibf} = 4'h1 << k;
    @(negedge clk);
    {ext, mbx, obf, ibf} = 4'h0;
  endtask : pulse
  task automatic done_t(input string s);
    $display("test %s ended, %0d compares", s, checked);
  endtask : done_t
  // Main sequence; control writes keep the reserved low bits at zero.
  initial
  begin
    {rd_s, wr_s, busy, mbx, obf, ibf, ext, addr, wd} = '0;
    pass = 1;
    rst = 1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 0;
    rd(2'h0);
    check(rdat, 8'h80);
    rd(2'h2);
    check(rdat, 8'h00);
    wait_st(7, 0);
    rd(2'h0);
    check(rdat, 8'h30);
    rd(2'h0);
    check(rdat, 8'h30);
    done_t("reset");
    acc(1, 10'h234, 8'h12);
    acc(0, 10'h231, 8'h00);
    check(rdat, 8'h00);
    wr(2'h3, 8'hff);
    rd(2'h3);
    check(rdat, 8'h00);
    rd(2'h0);
    check(rdat, 8'h30);
    done_t("decode");
    wr(2'h1, 8'h12);
    rd(2'h0);
    check(rdat & 8'h08, 8'h08);
    check(cb, 8'h12);
    wait_st(2, 1);
    rd(2'h0);
    check(rdat & 8'h0c, 8'h04);
    rd(2'h2);
    check(rdat, 8'h00);
    rd(2'h1);
    check(rdat, 8'hed);
    rd(2'h0);
    check(rdat & 8'h04, 8'h00);
    rd(2'h2);
    check(rdat, 8'h84);
    check(irq, 1);
    pulse(1);
    rd(2'h2);
    check(rdat, 8'h84);
    wr(2'h0, 8'h20);
    rd(2'h2);
    check(rdat, 8'h82);
    wr(2'h0, 8'h20);
    rd(2'h2);
    check(rdat, 8'h00);
    check(irq, 0);
    pulse(0);
    rd(2'h2);
    check(rdat, 8'h81);
    wr(2'h0, 8'h20);
    done_t("command");
    wr(2'h1, 8'hff);
    wait_st(3, 0);
    rd(2'h0);
    check(rdat & 8'h01, 8'h01);
    rd(2'h2);
    check(rdat, 8'h84);
    wr(2'h0, 8'h20);
    pulse(2);
    busy = 1;
    rd(2'h0);
    check(rdat & 8'h30, 8'h00);
    busy = 0;
    done_t("bad_and_idle");
    wr(2'h0, 8'h10);
    for (n = 0; n < 1000 && logic_reset_abandon === 1; n++)
      @(negedge clk);
    check(n[15:0], 16'(`HP_BUSRST_CYC));
    if (n >= 1000)
      close_out();
    rd(2'h2);
    check(rdat, 8'h00);
    pulse(3);
    rd(2'h2);
    check(rdat, 8'h88);
    done_t("bus_reset");
    pass = 0;
    wr(2'h0, 8'h80);
    check({prst, logic_reset_abandon}, 2'h3);
    rd(2'h0);
    check(rdat, 8'h80);
    rd(2'h2);
    check({irq, rdat}, 9'h000);
    wait_st(7, 0);
    rd(2'h0);
    check(rdat & 8'hc0, 8'h40);
    // The full reset is still driving the bus; let it end so the logic reset is seen alone.
    for (n = 0; n < 1000 && logic_reset_abandon === 1; n++)
      @(negedge clk);
    if (n >= 1000)
    begin
      mismatches++;
      close_out();
    end
    pulse(0);
    wr(2'h0, 8'h40);
    check({abd, logic_reset_abandon}, 2'h2);
    rd(2'h0);
    check(rdat & 8'h70, 8'h70);
    rd(2'h2);
    check(rdat, 8'h00);
    pass = 1;
    wr(2'h0, 8'h80);
    wait_st(7, 0);
    rd(2'h0);
    check(rdat, 8'h30);
    done_t("full_reset");
    wr(2'h1, 8'h20);
    repeat (60) @(negedge clk);
    check(rr, 0);
    for (int i = 0; i < 20; i++)
    begin
      wait_st(2, 1);
      rd(2'h1);
      check(rdat, 8'(i));
    end
    rd(2'h2);
    check(rdat, 8'h84);
    done_t("reply_buffer");
    close_out();
  end
endmodule : host_io_port_interface_tb_top
